//--- rtl/cfs_config.v
`timescale 1ns/10ps
`default_nettype none
`include "cfs_map.vh"

// Contract
// RULE_01 - eleven-bit shift feeds eleven-bit control
// RULE_02 - enabled pulse shifts input into first stage
// RULE_03 - eleven shifts, twelfth pulse commits control
// RULE_04 - bit n governs output pair nine-minus-n
// RULE_05 - bit ten picks clock a or b
// RULE_06 - low enable bit disables its pair
// RULE_07 - pulse with enable low resets all
// RULE_08 - one load only per reset
// RULE_09 - enable low keeps all pairs on
// RULE_10 - enable low: serial pin picks clock
// RULE_11 - both pins low is default state
// RULE_12 - controller keeps shift clock under limit
// RULE_13 - floating pins give default state
// RULE_14 - act on shift clock rising edge
// RULE_15 - reset control state held until load
module cfs_config
#(
    parameter NUM_OUT = `CFS_NUM_OUTPUTS
)
(
    input  wire               sys_clk,
    input  wire               reset,
    input  wire               config_shift_clock,
    input  wire               serial_config_input,
    input  wire               program_enable,
    output reg  [NUM_OUT-1:0] pairEnable_reg,
    output reg                inputSelect_reg,
    output reg                ctrlLoaded_reg,
    output reg  [10:0]        ctrlWord_reg
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire ckSync;
    wire ckRise;
    wire siSync;
    wire enSync;

    // RULE_13 pad idle levels
    // reset levels equal the pad pulls, so an idle-high shift
    // clock is not taken for a rising edge once reset lifts
    cfs_edge_sync
    #(
        .IDLE_LEVEL (1'b1)
    )
    ckSyncInst
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .asyncIn   (config_shift_clock),
        .syncOut   (ckSync),
        .risePulse (ckRise)
    );

    cfs_edge_sync
    #(
        .IDLE_LEVEL (1'b0)
    )
    siSyncInst
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .asyncIn   (serial_config_input),
        .syncOut   (siSync),
        .risePulse ()
    );

    cfs_edge_sync
    #(
        .IDLE_LEVEL (1'b0)
    )
    enSyncInst
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .asyncIn   (program_enable),
        .syncOut   (enSync),
        .risePulse ()
    );

    // data pins are delayed one more stage so that they line up
    // with the edge pulse, which lags the synchronised clock by one
    // limitation: the shift clock must stay high and low for two
    // clocks each, or an edge is lost in the synchroniser
    reg siAlign_reg;
    reg enAlign_reg;

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            siAlign_reg <= 1'b0;
            enAlign_reg <= 1'b0;
        end
        else
        begin
            siAlign_reg <= siSync;
            enAlign_reg <= enSync;
        end
    end

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    localparam [2:0] ST_SHIFT  = 3'h1;
    localparam [2:0] ST_COMMIT = 3'h2;
    localparam [2:0] ST_DONE   = 3'h4;

    reg [2:0]                 state_reg;
    reg [2:0]                 state_next;
    reg [`CFS_CNT_WIDTH-1:0]  count_reg;
    reg [`CFS_CNT_WIDTH-1:0]  count_next;
    reg [`CFS_CTRL_WIDTH-1:0] shift_reg;
    reg [`CFS_CTRL_WIDTH-1:0] shift_next;
    reg [`CFS_CTRL_WIDTH-1:0] ctrl_reg;
    reg [`CFS_CTRL_WIDTH-1:0] ctrl_next;
    reg                       loaded_reg;
    reg                       loaded_next;

    // index of the last shift pulse, cut to the counter width
    localparam integer              SHIFT_LAST_INT = `CFS_LOAD_PULSE - 2;
    localparam [`CFS_CNT_WIDTH-1:0] SHIFT_LAST     =
        SHIFT_LAST_INT[`CFS_CNT_WIDTH-1:0];

    // RULE_03 last of the eleven shifts
    wire lastShift = (count_reg == SHIFT_LAST);

    always @*
    begin
        state_next  = state_reg;
        count_next  = count_reg;
        shift_next  = shift_reg;
        ctrl_next   = ctrl_reg;
        loaded_next = loaded_reg;
        // RULE_14 rising edge only
        if (ckRise)
        begin
            if (!enAlign_reg)
            begin
                // RULE_07 reset everything
                state_next  = ST_SHIFT;
                count_next  = {`CFS_CNT_WIDTH{1'b0}};
                shift_next  = `CFS_SHIFT_RESET;
                ctrl_next   = `CFS_CTRL_RESET;
                loaded_next = 1'b0;
            end
            else
            begin
                case (state_reg)
                    ST_SHIFT:
                    begin
                        // RULE_02 serial shift in
                        shift_next = {shift_reg[`CFS_CTRL_WIDTH-2:0],
                                      siAlign_reg};
                        count_next = count_reg + 1'b1;
                        // RULE_03 eleventh bit in
                        if (lastShift)
                            state_next = ST_COMMIT;
                    end
                    ST_COMMIT:
                    begin
                        // RULE_03 twelfth pulse loads
                        ctrl_next   = shift_reg;
                        loaded_next = 1'b1;
                        state_next  = ST_DONE;
                    end
                    ST_DONE:
                    begin
                        // RULE_08 further pulses ignored
                        // a second frame is refused, not loaded; only a system
                        // reset or a pulse with enable low reopens the register
                        state_next = ST_DONE;
                    end
                    default:
                    begin
                        // stray state code: start a clean frame
                        state_next = ST_SHIFT;
                        count_next = {`CFS_CNT_WIDTH{1'b0}};
                        shift_next = `CFS_SHIFT_RESET;
                    end
                endcase
            end
        end
    end

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_reg <= ST_SHIFT;
            count_reg <= {`CFS_CNT_WIDTH{1'b0}};
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // ----------------------------------------
    // shift and control registers
    // ----------------------------------------
    // RULE_01 shift stages feed the control word
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            shift_reg  <= `CFS_SHIFT_RESET;
            ctrl_reg   <= `CFS_CTRL_RESET;
            loaded_reg <= 1'b0;
        end
        else
        begin
            shift_reg  <= shift_next;
            ctrl_reg   <= ctrl_next;
            loaded_reg <= loaded_next;
        end
    end

    // ----------------------------------------
    // output decode
    // ----------------------------------------
    // bitOrder has already put the first bit shifted at bit 0, so reverse
    // the ten enables to land bit n on pair 9-n
    function [NUM_OUT-1:0] pairMap;
        input [`CFS_CTRL_WIDTH-1:0] word;
        integer i;
        begin
            pairMap = {NUM_OUT{1'b0}};
            for (i = 0; i < NUM_OUT; i = i + 1)
                pairMap[NUM_OUT-1-i] = word[i];
        end
    endfunction

    // serial bit k sits at shift position 10-k; rebuild bit order
    function [`CFS_CTRL_WIDTH-1:0] bitOrder;
        input [`CFS_CTRL_WIDTH-1:0] word;
        integer i;
        begin
            bitOrder = {`CFS_CTRL_WIDTH{1'b0}};
            for (i = 0; i < `CFS_CTRL_WIDTH; i = i + 1)
                bitOrder[i] = word[`CFS_CTRL_WIDTH-1-i];
        end
    endfunction

    wire [`CFS_CTRL_WIDTH-1:0] ctrlBits = bitOrder(ctrl_reg);

    // ----------------------------------------
    // output select
    // ----------------------------------------
    // mode comes from the synchronised pin, not the aligned copy:
    // it only has to settle, not to line up with a shift edge
    reg [NUM_OUT-1:0] pairEnable_next;
    reg               inputSelect_next;

    always @*
    begin
        pairEnable_next  = {NUM_OUT{1'b1}};
        inputSelect_next = 1'b0;
        if (!enSync)
        begin
            // RULE_09 all pairs enabled
            pairEnable_next  = {NUM_OUT{1'b1}};
            // RULE_10 pin picks clock
            inputSelect_next = siSync;
        end
        else
        begin
            // RULE_06 per-pair gating
            // RULE_04 reversed pair order
            // RULE_15 reset word until load
            pairEnable_next  = pairMap(ctrlBits);
            // RULE_05 bit ten select
            inputSelect_next = ctrlBits[`CFS_SEL_BIT];
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            // RULE_11 default: all on, clock a
            pairEnable_reg  <= {NUM_OUT{1'b1}};
            inputSelect_reg <= 1'b0;
            ctrlLoaded_reg  <= 1'b0;
            ctrlWord_reg    <= `CFS_CTRL_RESET;
        end
        else
        begin
            ctrlLoaded_reg  <= loaded_reg;
            ctrlWord_reg    <= ctrlBits;
            pairEnable_reg  <= pairEnable_next;
            inputSelect_reg <= inputSelect_next;
        end
    end

endmodule

`default_nettype wire

//--- rtl/cfs_edge_sync.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// two-stage synchroniser with rise pulse
// ----------------------------------------
module cfs_edge_sync
#(
    parameter [0:0] IDLE_LEVEL = 1'b0
)
(
    input  wire sys_clk,
    input  wire reset,
    input  wire asyncIn,
    output reg  syncOut,
    output reg  risePulse
);

    reg metaReg;
    reg lastReg;

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            metaReg   <= IDLE_LEVEL;
            syncOut   <= IDLE_LEVEL;
            lastReg   <= IDLE_LEVEL;
            risePulse <= 1'b0;
        end
        else
        begin
            metaReg   <= asyncIn;
            syncOut   <= metaReg;
            lastReg   <= syncOut;
            risePulse <= syncOut & ~lastReg;
        end
    end

endmodule

`default_nettype wire

//--- rtl/cfs_map.vh
`ifndef CFS_MAP_VH
`define CFS_MAP_VH

// ----------------------------------------
// widths and fields
// ----------------------------------------
`define CFS_NUM_OUTPUTS      10
`define CFS_CTRL_WIDTH       11
`define CFS_SEL_BIT          10
`define CFS_LOAD_PULSE       12
`define CFS_CNT_WIDTH        4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CFS_CTRL_RESET       11'h000
`define CFS_SHIFT_RESET      11'h000

`endif

//--- sim/cfs_config_props.sv
`timescale 1ns/10ps
`default_nettype none
module cfs_config_props
#(
    parameter NUM_OUT = 10
)
(
    input wire logic               sys_clk,
    input wire logic               reset,
    input wire logic               config_shift_clock,
    input wire logic               serial_config_input,
    input wire logic               program_enable,
    input wire logic [NUM_OUT-1:0] pairEnable_reg,
    input wire logic               inputSelect_reg,
    input wire logic               ctrlLoaded_reg,
    input wire logic [10:0]        ctrlWord_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ----
    // checks
    // ----
    // pair p reads serial bit 9-p
    function automatic logic [9:0] rv(input logic [10:0] w);
        for (int n = 0; n < 10; n++)
            rv[9-n] = w[n];
    endfunction
    pair_map_a: assert property (program_enable[*6] ##0 ctrlLoaded_reg[*3]
        |-> pairEnable_reg == rv(ctrlWord_reg)) else $error("pair map");
    clk_sel_a: assert property (program_enable[*6] ##0 ctrlLoaded_reg[*3]
        |-> inputSelect_reg == ctrlWord_reg[10]) else $error("select");
    std_on_a: assert property (!program_enable[*6]
        |-> &pairEnable_reg) else $error("pairs off");
    direct_sel_a: assert property ((!program_enable &&
        $stable(serial_config_input))[*6]
        |-> inputSelect_reg == serial_config_input) else $error("direct sel");
    // loaded stays low past the window, so a late load cannot hide
    unload_a: assert property ((program_enable && !ctrlLoaded_reg)[*8]
        |-> $past(pairEnable_reg, 2) == '0 && !$past(inputSelect_reg, 2))
        else $error("unloaded state");
    one_load_a: assert property (ctrlLoaded_reg && $past(ctrlLoaded_reg)
        |-> $stable(ctrlWord_reg)) else $error("second load");
    load_mode_a: assert property ($rose(ctrlLoaded_reg)
        |-> program_enable && $past(program_enable, 8)) else $error("load");
    pin_clear_a: assert property ($fell(ctrlLoaded_reg)
        |-> !program_enable && ctrlWord_reg == 11'h000) else $error("clear");
    sys_reset_a: assert property (disable iff (1'b0) reset |=>
        &pairEnable_reg && !inputSelect_reg && !ctrlLoaded_reg)
        else $error("reset state");
    cover property ($rose(ctrlLoaded_reg));
    cover property ($fell(ctrlLoaded_reg));
    cover property ($rose(inputSelect_reg));
endmodule
bind cfs_config cfs_config_props #(.NUM_OUT(NUM_OUT)) cfs_config_props_i
(
    .sys_clk(sys_clk), .reset(reset), .config_shift_clock(config_shift_clock),
    .serial_config_input(serial_config_input),
    .program_enable(program_enable), .pairEnable_reg(pairEnable_reg),
    .inputSelect_reg(inputSelect_reg), .ctrlLoaded_reg(ctrlLoaded_reg),
    .ctrlWord_reg(ctrlWord_reg)
);
`default_nettype wire

//--- sim/cfs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cfs_host_model
(
    input wire logic sys_clk,
    output logic     shiftClk,
    output logic     serialIn,
    output logic     progEn
);
    initial
    begin
        shiftClk = 1'b1;
        serialIn = 1'b0;
        progEn = 1'b0;
    end
    task pins(input logic e, input logic s);
        @(negedge sys_clk);
        progEn = e;
        serialIn = s;
    endtask
    // 80 ns period, data held 4 cycles each side
    task pulse(input logic d);
        @(negedge sys_clk);
        serialIn = d;
        shiftClk = 1'b0;
        repeat (4) @(negedge sys_clk);
        shiftClk = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    task send(input logic [10:0] w);
        for (int n = 0; n < 11; n++)
            pulse(w[n]);
    endtask
endmodule
`default_nettype wire

//--- sim/clock_fanout_serial_config_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module clock_fanout_serial_config_test;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        shiftClk, serialIn, progEn, selOut, loaded;
    logic [9:0]  pairOut;
    logic [10:0] word;
    int          miscompares = 0;
    int          checksDone = 0;
    always #5 sys_clk = ~sys_clk;
    cfs_host_model cfs_host_model_i (.sys_clk(sys_clk), .shiftClk(shiftClk),
        .serialIn(serialIn), .progEn(progEn));
    cfs_config cfs_config_i (.sys_clk(sys_clk), .reset(reset),
        .config_shift_clock(shiftClk), .serial_config_input(serialIn),
        .program_enable(progEn), .pairEnable_reg(pairOut),
        .inputSelect_reg(selOut), .ctrlLoaded_reg(loaded), .ctrlWord_reg(word));
    function automatic logic [9:0] rv(input logic [10:0] w);
        for (int n = 0; n < 10; n++)
            rv[9-n] = w[n];
    endfunction
    // outputs settle within five cycles after a pin edge
    task look(input logic [9:0] pe, input logic sel, input logic ld);
        repeat (8) @(negedge sys_clk);
        `CHK(pairOut, pe)
        `CHK(selOut, sel)
        `CHK(loaded, ld)
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        miscompares++;
        wrap_up;
    end
    initial
    begin
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        look(10'h3ff, 1'b0, 1'b0);
        cfs_host_model_i.pins(1'b0, 1'b1);
        look(10'h3ff, 1'b1, 1'b0);
        $display("standard mode done");
        cfs_host_model_i.pins(1'b0, 1'b0);
        cfs_host_model_i.pulse(1'b0);
        cfs_host_model_i.pins(1'b1, 1'b0);
        look(10'h000, 1'b0, 1'b0);
        cfs_host_model_i.send(11'h4a5);
        look(10'h000, 1'b0, 1'b0);
        cfs_host_model_i.pulse(1'b0);
        look(rv(11'h4a5), 1'b1, 1'b1);
        `CHK(word, 11'h4a5)
        $display("first load done");
        cfs_host_model_i.send(11'h15a);
        cfs_host_model_i.pulse(1'b1);
        look(rv(11'h4a5), 1'b1, 1'b1);
        cfs_host_model_i.pins(1'b0, 1'b0);
        look(10'h3ff, 1'b0, 1'b1);
        cfs_host_model_i.pulse(1'b1);
        look(10'h3ff, 1'b1, 1'b0);
        `CHK(word, 11'h000)
        cfs_host_model_i.pins(1'b1, 1'b0);
        cfs_host_model_i.send(11'h15a);
        cfs_host_model_i.pulse(1'b0);
        look(rv(11'h15a), 1'b0, 1'b1);
        $display("reload done");
        reset = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        look(10'h000, 1'b0, 1'b0);
        cfs_host_model_i.send(11'h6f0);
        cfs_host_model_i.pulse(1'b1);
        look(rv(11'h6f0), 1'b1, 1'b1);
        `CHK(word, 11'h6f0)
        $display("reset rerun done");
        wrap_up;
    end
endmodule
`default_nettype wire
